// ---- ldlp_line_model.sv ----
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////
// far-end line equipment: recovered clock runs only inside a frame
module ldlp_line_model
(
  // frame control from the bench
  input  wire logic en,
  input  wire logic val,
  // recovered line pins
  output logic      lclk,
  output logic      ldata
);
  // clock stands still low between frames, 160 ns period inside
  initial lclk = 1'b0;
  always #80 lclk = en ? ~lclk : 1'b0;
  // data moves on the falling edge; a released line shows the inverse
  initial ldata = 1'b0;
  always @(negedge lclk or negedge en) ldata <= en ? val : ~ldata;
endmodule : ldlp_line_model

// ---- ldlp_pkg.sv ----
package ldlp_pkg;
  //////////////////////////////////////////////////////////////////
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_CTRL1   = 8'h01;
  localparam logic [7:0] IDX_CTRL3   = 8'h03;
  localparam logic [7:0] IDX_CTRL6   = 8'h06;
  localparam logic [7:0] IDX_STATUS  = 8'h08;
  localparam logic [7:0] IDX_CODECTL = 8'h0a;
  localparam logic [7:0] IDX_TX_LO   = 8'h0b;
  localparam logic [7:0] IDX_TX_HI   = 8'h0c;
  localparam logic [7:0] IDX_UP_LO   = 8'h0d;
  localparam logic [7:0] IDX_UP_HI   = 8'h0e;
  localparam logic [7:0] IDX_DN_LO   = 8'h0f;
  localparam logic [7:0] IDX_DN_HI   = 8'h10;
  localparam logic [7:0] IDX_ERR_HI  = 8'h11;
  localparam logic [7:0] IDX_ERR_LO  = 8'h12;
  localparam logic [7:0] REG_RESET   = 8'h00;
  //////////////////////////////////////////////////////////////////
  // field positions
  localparam int B_STD      = 7;  // ctrl1: 1 = t1, 0 = e1
  localparam int B_ALL_ONES = 7;  // ctrl3
  localparam int B_PRBS_TX  = 4;  // ctrl3
  localparam int B_CODE_TX  = 3;  // ctrl3
  localparam int B_LLB      = 7;  // ctrl6
  localparam int B_RLB      = 6;  // ctrl6
  localparam int B_AUTO_REMOTE_LOOP_ENABLE    = 5;  // ctrl6
  localparam int B_ALB      = 4;  // ctrl6
  localparam int B_ERROR_COUNT_SOURCE_TOP    = 2;  // ctrl6
  localparam int B_LUP      = 7;  // status
  localparam int B_LDN      = 6;  // status
  localparam int B_AUTO     = 1;  // status
  localparam int B_SYNC     = 0;  // status
  localparam int B_TXLEN    = 6;  // code control, two bits
  localparam int B_UPLEN    = 3;  // code control, three bits
  localparam int B_DNLEN    = 0;  // code control, three bits
  //////////////////////////////////////////////////////////////////
  // code length encodings
  localparam logic [1:0] TXLEN_5    = 2'h0;
  localparam logic [1:0] TXLEN_6    = 2'h1;
  localparam logic [1:0] TXLEN_7    = 2'h2;
  localparam logic [2:0] RXLEN_LONG = 3'h7;
  localparam logic [4:0] LEN_LONG   = 5'h10;
  //////////////////////////////////////////////////////////////////
  // timing, counted in line bits of the recovered clock
  localparam int E1_RATE_HZ = 2048000;
  localparam int T1_RATE_HZ = 1544000;
  localparam int QUAL_S     = 5;
  localparam int INTEG_MS   = 48;
  localparam int ERR_RATIO  = 100;
  localparam int QUAL_E1_BITS  = QUAL_S * E1_RATE_HZ;
  localparam int QUAL_T1_BITS  = QUAL_S * T1_RATE_HZ;
  localparam int INTEG_E1_BITS = INTEG_MS * E1_RATE_HZ / 1000;
  localparam int INTEG_T1_BITS = INTEG_MS * T1_RATE_HZ / 1000;
  // prbs synchroniser
  localparam logic [6:0]  SYNC_BITS = 7'h40;
  localparam logic [6:0]  LOSS_ERRS = 7'h06;
  localparam logic [19:0] PRBS_SEED = 20'h00001;
  //////////////////////////////////////////////////////////////////
  typedef enum logic {AUTO_OFF = 1'b0, AUTO_LOOPED = 1'b1} ldlp_auto_t;
  typedef enum logic {SYNC_HUNT = 1'b0, SYNC_LOCKED = 1'b1} ldlp_sync_t;
endpackage : ldlp_pkg

// ---- ldlp_prbs.sv ----
`timescale 1ns/1ps
// prbs generator and two-pattern receive synchroniser
module ldlp_prbs
  import ldlp_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // transmit side
  input  wire logic tx_step,
  input  wire logic std_t1,
  output logic      tx_bit,
  // receive side
  input  wire logic rx_step,
  input  wire logic rx_bit,
  output logic      synced,
  output logic      err_pulse,
  output logic      err_event
);
  typedef struct packed {
    logic [19:0] gen;   // generator lfsr
    logic [19:0] chk;   // received bits, shared by both checkers
    ldlp_sync_t  sync;
    logic        sel20; // locked on the 20-stage pattern
    logic [6:0]  cln15; // error-free run, 15-stage
    logic [6:0]  cln20; // error-free run, 20-stage
    logic [63:0] hist;  // error flags of the last 64 bits
    logic [6:0]  errs;  // ones in hist
    logic        prbs_error_pulse_out;
    logic        ev;
  } ldlp_prbs_st_t;
  ldlp_prbs_st_t s, n;
  logic e15, e20, err_now, near64;
  assign e15 = rx_bit ^ s.chk[14] ^ s.chk[13];
  assign e20 = rx_bit ^ s.chk[19] ^ s.chk[16];
  assign err_now = s.sel20 ? e20 : e15;
  assign near64 = (s.cln15 == SYNC_BITS - 7'h01) || (s.cln20 == SYNC_BITS - 7'h01);
  //////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    n = s;
    n.ev = 1'b0;
    // 15-stage for e1, 20-stage for t1; a zero window reseeds itself
    if (tx_step)
    begin
      if (std_t1)
        n.gen = {s.gen[18:0], (s.gen[19] ^ s.gen[16]) | (s.gen == 20'h00000)};
      else
        n.gen = {s.gen[18:0], (s.gen[14] ^ s.gen[13]) | (s.gen[14:0] == 15'h0000)};
    end
    // search runs always, whatever the transmit side does
    if (rx_step)
    begin
      n.chk = {s.chk[18:0], rx_bit};
      case (s.sync)
        SYNC_HUNT:
        begin
          n.cln15 = e15 ? 7'h00 : ((s.cln15 < SYNC_BITS) ? s.cln15 + 7'h01 : s.cln15);
          n.cln20 = e20 ? 7'h00 : ((s.cln20 < SYNC_BITS) ? s.cln20 + 7'h01 : s.cln20);
          n.prbs_error_pulse_out = 1'b1;
          if (n.cln15 == SYNC_BITS || n.cln20 == SYNC_BITS)
          begin
            n.sync  = SYNC_LOCKED;
            n.sel20 = (n.cln20 == SYNC_BITS);
            n.hist  = 64'h0;
            n.errs  = 7'h00;
            n.prbs_error_pulse_out  = 1'b0;
          end
        end
        SYNC_LOCKED:
        begin
          // sliding count: add the new flag, drop the oldest
          n.hist = {s.hist[62:0], err_now};
          n.errs = s.errs + {6'h00, err_now} - {6'h00, s.hist[63]};
          n.prbs_error_pulse_out = err_now;
          n.ev   = err_now;
          if (n.errs >= LOSS_ERRS)
          begin
            n.sync  = SYNC_HUNT;
            n.cln15 = 7'h00;
            n.cln20 = 7'h00;
            n.prbs_error_pulse_out  = 1'b1;
          end
        end
        default: n.sync = SYNC_HUNT;
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s      <= '0;
      s.gen  <= PRBS_SEED;
      s.sync <= SYNC_HUNT;
      s.prbs_error_pulse_out <= 1'b1;
    end
    else
      s <= n;
  end
  assign tx_bit    = std_t1 ? s.gen[19] : s.gen[14];
  assign synced    = (s.sync == SYNC_LOCKED);
  assign err_pulse = s.prbs_error_pulse_out;
  assign err_event = s.ev;
  //////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_bit_err;
    rx_step && synced && err_now;
  endsequence
  AST_HUNT_HIGH: assert property (!synced |-> err_pulse)
    else $error("error output low while not synchronised");
  AST_LOCK_64: assert property ($rose(synced) |-> $past(near64))
    else $error("sync gained before 64 clean bits");
  AST_HOLD_SYNC: assert property ((synced && rx_step && s.errs < 7'h05) |=> synced)
    else $error("sync lost with fewer than six errors in span");
  AST_ERR_PULSE: assert property (s_bit_err |=> err_pulse && err_event)
    else $error("bit error gave no pulse");
endmodule : ldlp_prbs

// ---- ldlp_top.sv ----
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////
module ldlp_top
  import ldlp_pkg::*;
#(
  parameter int QUAL_E1  = QUAL_E1_BITS,
  parameter int QUAL_T1  = QUAL_T1_BITS,
  parameter int INTEG_E1 = INTEG_E1_BITS,
  parameter int INTEG_T1 = INTEG_T1_BITS
)(
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        SRST,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // line side, recovered clock and data
  input  wire logic        RX_LINE_CLK,
  input  wire logic        RX_LINE_DATA,
  output logic             TX_LINE_CLK,
  output logic             TX_LINE_DATA,
  // system side
  input  wire logic        TX_SYS_CLK,
  input  wire logic        TX_SYS_DATA,
  output logic             RX_SYS_CLK,
  output logic             RX_SYS_DATA,
  output logic             PRBS_ERR_OUT,
  // strap: high when configured by pins
  input  wire logic        HW_MODE
);
  typedef struct packed {
    // two-flop synchronisers plus edge history
    logic rxc1, rxc2, rxc3, rxd1, rxd2;
    logic txc1, txc2, txc3, txd1, txd2;
    logic hw1, hw2;
    // software registers
    logic [7:0] ctrl1, ctrl3, ctrl6, codectl;
    logic [7:0] tx_lo, tx_hi, up_lo, up_hi, dn_lo, dn_hi;
    // bus data phase
    logic        wr_pend;
    logic [7:0]  wr_idx;
    logic [31:0] rdata;
    // datapath outputs
    logic [3:0] tx_idx;
    logic       tx_data, tx_clk, tx_step_d, rx_data, rx_clk;
    // code detectors, 0 = loop-up, 1 = loop-down
    logic [15:0]       hist;
    logic [1:0]        dlock, dseen;
    logic [1:0][3:0]   didx;
    logic [1:0][16:0]  dbits;
    logic [1:0][10:0]  derrs;
    // automatic remote loopback
    ldlp_auto_t  auto_st;
    logic [23:0] qual_cnt;
    // error counter
    logic [15:0] err_cnt;
  } ldlp_top_st_t;
  ldlp_top_st_t s, n;
  //////////////////////////////////////////////////////////////////
  // code length and alignment helpers
  function automatic logic [4:0] rx_len(input logic [2:0] c);
    rx_len = (c == RXLEN_LONG) ? LEN_LONG : {2'h0, c} + 5'h01;
  endfunction : rx_len
  function automatic logic [4:0] tx_len(input logic [1:0] c);
    case (c)
      TXLEN_5: tx_len = 5'h05;
      TXLEN_6: tx_len = 5'h06;
      TXLEN_7: tx_len = 5'h07;
      default: tx_len = LEN_LONG;
    endcase
  endfunction : tx_len
  // short codes live at the top of the low byte, first bit highest
  function automatic logic [15:0] code_align(input logic [15:0] p,
                                             input logic [4:0]  len);
    if (len == LEN_LONG)
      code_align = p;
    else
      code_align = {8'h00, p[7:0]} >> (5'h08 - len);
  endfunction : code_align
  function automatic logic [15:0] code_mask(input logic [4:0] len);
    code_mask = (len == LEN_LONG) ? 16'hffff : 16'((17'h00001 << len) - 17'h00001);
  endfunction : code_mask
  function automatic logic code_bit(input logic [15:0] al, input logic [4:0] len,
                                    input logic [3:0] idx);
    code_bit = al[4'(len - 5'h01 - {1'b0, idx})];
  endfunction : code_bit
  //////////////////////////////////////////////////////////////////
  // decoded controls and stream strobes
  logic        std_t1, all_ones, prbs_tx, code_tx, local_loopback_enable, analog_loopback_enable, auto_remote_loop_enable, error_count_source_top;
  logic        rlb_eff, line_edge, sys_edge, tx_step, rx_edge, rx_bit;
  logic        prbs_bit, synced, prbs_ev, prbs_pulse, tx_first, qual_hit;
  logic [4:0]  txl;
  logic [15:0] tx_al;
  logic [23:0] qual_max;
  logic [16:0] integ;
  logic [10:0] err_lim;
  logic [1:0][4:0]  det_len;
  logic [1:0][15:0] det_al, det_mask;
  logic        addr_ok;
  logic [7:0]  addr_idx, rd_byte;
  assign std_t1   = s.ctrl1[B_STD];
  assign all_ones = s.ctrl3[B_ALL_ONES];
  assign prbs_tx  = s.ctrl3[B_PRBS_TX];
  assign code_tx  = s.ctrl3[B_CODE_TX];
  assign local_loopback_enable      = s.ctrl6[B_LLB];
  assign analog_loopback_enable      = s.ctrl6[B_ALB];
  assign auto_remote_loop_enable    = s.ctrl6[B_AUTO_REMOTE_LOOP_ENABLE];
  assign error_count_source_top    = s.ctrl6[B_ERROR_COUNT_SOURCE_TOP];
  // remote loop from software or the code detector; pin mode forbids
  // combining it with local loop
  assign rlb_eff   = (s.ctrl6[B_RLB] | (s.auto_st == AUTO_LOOPED))
                     & ~(local_loopback_enable & s.hw2);
  assign line_edge = s.rxc2 & ~s.rxc3;
  assign sys_edge  = s.txc2 & ~s.txc3;
  // in remote loop the transmitter runs on the recovered clock
  assign tx_step   = rlb_eff ? line_edge : sys_edge;
  // receive stream: local loop takes system data, analog loop takes the
  // transmitter, otherwise the line; the line is ignored in both loops
  assign rx_edge   = local_loopback_enable ? sys_edge : (analog_loopback_enable ? s.tx_step_d : line_edge);
  assign rx_bit    = local_loopback_enable ? s.txd2 : (analog_loopback_enable ? s.tx_data : s.rxd2);
  assign txl       = tx_len(s.codectl[B_TXLEN +: 2]);
  assign tx_al     = code_align({s.tx_hi, s.tx_lo}, txl);
  assign tx_first  = code_bit(tx_al, txl, 4'h0);
  assign qual_max  = std_t1 ? 24'(QUAL_T1) : 24'(QUAL_E1);
  assign qual_hit  = (s.qual_cnt == qual_max - 24'h000001);
  assign integ     = std_t1 ? 17'(INTEG_T1) : 17'(INTEG_E1);
  assign err_lim   = 11'(integ / 17'(ERR_RATIO));
  // per-detector length and aligned code
  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_det
      assign det_len[g]  = rx_len(s.codectl[(g == 0 ? B_UPLEN : B_DNLEN) +: 3]);
      assign det_al[g]   = code_align(g == 0 ? {s.up_hi, s.up_lo} : {s.dn_hi, s.dn_lo},
                                      det_len[g]);
      assign det_mask[g] = code_mask(det_len[g]);
    end
  endgenerate
  //////////////////////////////////////////////////////////////////
  // bus address decode and read mux
  assign addr_ok  = HSEL & HTRANS[1] & HREADY & (HADDR[31:10] == 22'h000000);
  assign addr_idx = HADDR[9:2];
  always_comb
  begin
    case (addr_idx)
      IDX_CTRL1:   rd_byte = s.ctrl1;
      IDX_CTRL3:   rd_byte = s.ctrl3;
      IDX_CTRL6:   rd_byte = s.ctrl6;
      IDX_STATUS:  rd_byte = {s.dseen[0], s.dseen[1], 4'h0,
                              s.auto_st == AUTO_LOOPED, synced};
      IDX_CODECTL: rd_byte = s.codectl;
      IDX_TX_LO:   rd_byte = s.tx_lo;
      IDX_TX_HI:   rd_byte = s.tx_hi;
      IDX_UP_LO:   rd_byte = s.up_lo;
      IDX_UP_HI:   rd_byte = s.up_hi;
      IDX_DN_LO:   rd_byte = s.dn_lo;
      IDX_DN_HI:   rd_byte = s.dn_hi;
      IDX_ERR_HI:  rd_byte = s.err_cnt[15:8];
      IDX_ERR_LO:  rd_byte = s.err_cnt[7:0];
      default:     rd_byte = 8'h00; // unmapped reads zero
    endcase
  end
  //////////////////////////////////////////////////////////////////
  // prbs generator and checker
  ldlp_prbs u_prbs (
    .clk       (CLK_SYS),
    .srst      (SRST),
    .tx_step   (tx_step),
    .std_t1    (std_t1),
    .tx_bit    (prbs_bit),
    .rx_step   (rx_edge),
    .rx_bit    (rx_bit),
    .synced    (synced),
    .err_pulse (prbs_pulse),
    .err_event (prbs_ev)
  );
  //////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    logic       d_exp;
    logic [3:0] d_last;
    d_exp  = 1'b0;
    d_last = 4'h0;
    n = s;
    // synchronisers: the first stage feeds only the second
    n.rxc1 = RX_LINE_CLK;
    n.rxc2 = s.rxc1;
    n.rxc3 = s.rxc2;
    n.rxd1 = RX_LINE_DATA;
    n.rxd2 = s.rxd1;
    n.txc1 = TX_SYS_CLK;
    n.txc2 = s.txc1;
    n.txc3 = s.txc2;
    n.txd1 = TX_SYS_DATA;
    n.txd2 = s.txd1;
    n.hw1  = HW_MODE;
    n.hw2  = s.hw1;
    // write data phase, low byte only
    n.wr_pend = 1'b0;
    if (s.wr_pend)
    begin
      case (s.wr_idx)
        IDX_CTRL1:   n.ctrl1   = HWDATA[7:0];
        IDX_CTRL3:   n.ctrl3   = HWDATA[7:0];
        IDX_CTRL6:   n.ctrl6   = HWDATA[7:0];
        IDX_CODECTL: n.codectl = HWDATA[7:0];
        IDX_TX_LO:   n.tx_lo   = HWDATA[7:0];
        IDX_TX_HI:   n.tx_hi   = HWDATA[7:0];
        IDX_UP_LO:   n.up_lo   = HWDATA[7:0];
        IDX_UP_HI:   n.up_hi   = HWDATA[7:0];
        IDX_DN_LO:   n.dn_lo   = HWDATA[7:0];
        IDX_DN_HI:   n.dn_hi   = HWDATA[7:0];
        default:     n.wr_pend = 1'b0; // read-only or unmapped
      endcase
    end
    // address phase: latch writes, answer reads in the next cycle
    if (addr_ok)
    begin
      if (HWRITE)
      begin
        n.wr_pend = (HSIZE == 3'h2);
        n.wr_idx  = addr_idx;
      end
      else
        n.rdata = {24'h000000, rd_byte};
    end
    // transmit line: all ones wins, then remote loop, prbs, code, system
    n.tx_step_d = tx_step;
    n.tx_clk    = rlb_eff ? s.rxc2 : s.txc2;
    if (tx_step)
    begin
      n.tx_idx = (s.tx_idx == 4'(txl - 5'h01)) ? 4'h0 : s.tx_idx + 4'h1;
      if (all_ones)
        n.tx_data = 1'b1;
      else if (rlb_eff)
        n.tx_data = s.rxd2;
      else if (prbs_tx)
        n.tx_data = prbs_bit;
      else if (code_tx)
        n.tx_data = code_bit(tx_al, txl, s.tx_idx);
      else
        n.tx_data = s.txd2;
    end
    // receive outputs stay live in every mode
    n.rx_clk = local_loopback_enable ? s.txc2 : (analog_loopback_enable ? s.tx_clk : s.rxc2);
    if (rx_edge)
      n.rx_data = rx_bit;
    // code detectors: align on a full match, then integrate errors
    if (rx_edge)
    begin
      n.hist = {s.hist[14:0], rx_bit};
      for (int i = 0; i < 2; i++)
      begin
        if (!s.dlock[i])
        begin
          if (((n.hist ^ det_al[i]) & det_mask[i]) == 16'h0000)
          begin
            n.dlock[i] = 1'b1;
            n.didx[i]  = 4'h0;
            n.dbits[i] = 17'h00000;
            n.derrs[i] = 11'h000;
          end
        end
        else
        begin
          d_exp  = code_bit(det_al[i], det_len[i], s.didx[i]);
          d_last = 4'(det_len[i] - 5'h01);
          n.didx[i]  = (s.didx[i] == d_last) ? 4'h0 : s.didx[i] + 4'h1;
          n.dbits[i] = s.dbits[i] + 17'h00001;
          if (d_exp != rx_bit && s.derrs[i] != 11'h7ff)
            n.derrs[i] = s.derrs[i] + 11'h001;
          // window end: flag only if errors stayed within the ratio
          if (n.dbits[i] == integ)
          begin
            n.dseen[i] = (n.derrs[i] <= err_lim);
            n.dlock[i] = n.dseen[i];
            n.dbits[i] = 17'h00000;
            n.derrs[i] = 11'h000;
          end
        end
      end
    end
    // automatic remote loopback, timed in recovered-clock bits
    if (!auto_remote_loop_enable)
    begin
      n.auto_st  = AUTO_OFF;
      n.qual_cnt = 24'h000000;
    end
    else if (line_edge)
    begin
      case (s.auto_st)
        AUTO_OFF:
        begin
          n.qual_cnt = s.dseen[0] ? s.qual_cnt + 24'h000001 : 24'h000000;
          if (s.dseen[0] && qual_hit)
          begin
            n.auto_st  = AUTO_LOOPED;
            n.qual_cnt = 24'h000000;
          end
        end
        AUTO_LOOPED:
        begin
          n.qual_cnt = s.dseen[1] ? s.qual_cnt + 24'h000001 : 24'h000000;
          if (s.dseen[1] && qual_hit)
          begin
            n.auto_st  = AUTO_OFF;
            n.qual_cnt = 24'h000000;
          end
        end
        default: n.auto_st = AUTO_OFF;
      endcase
    end
    // saturating prbs error count
    if (prbs_ev && error_count_source_top && s.err_cnt != 16'hffff)
      n.err_cnt = s.err_cnt + 16'h0001;
  end
  //////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      s         <= '0;
      s.ctrl1   <= REG_RESET;
      s.ctrl3   <= REG_RESET;
      s.ctrl6   <= REG_RESET;
      s.codectl <= REG_RESET;
      s.auto_st <= AUTO_OFF;
    end
    else
      s <= n;
  end
  // outputs straight from flops; HREADYOUT and HRESP are tied to constants
  assign HRDATA       = s.rdata;
  assign HREADYOUT    = 1'b1;
  assign HRESP        = 1'b0;
  assign TX_LINE_CLK  = s.tx_clk;
  assign TX_LINE_DATA = s.tx_data;
  assign RX_SYS_CLK   = s.rx_clk;
  assign RX_SYS_DATA  = s.rx_data;
  assign PRBS_ERR_OUT = prbs_pulse;
  //////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  AST_CODE_FIRST: assert property ((tx_step && code_tx && !prbs_tx && !rlb_eff
      && !all_ones && s.tx_idx == 4'h0) |=> TX_LINE_DATA == $past(tx_first))
    else $error("pattern did not start with its first bit");
  AST_REMOTE: assert property ((tx_step && rlb_eff && !all_ones)
      |=> TX_LINE_DATA == $past(s.rxd2))
    else $error("remote loop did not send recovered data");
  AST_LOCAL: assert property ((rx_edge && local_loopback_enable) |=> RX_SYS_DATA == $past(s.txd2))
    else $error("local loop did not mirror system data");
  AST_ONES: assert property ((tx_step && all_ones) |=> TX_LINE_DATA)
    else $error("all ones not sent");
  AST_AUTO_OFF: assert property (!auto_remote_loop_enable |=> s.auto_st == AUTO_OFF)
    else $error("auto loop held with enable clear");
  AST_AUTO_ENTER: assert property ($rose(s.auto_st) |-> $past(qual_hit))
    else $error("auto loop entered before qualification");
  AST_PIN_DUAL: assert property ((s.hw2 && local_loopback_enable) |-> !rlb_eff)
    else $error("dual loop in pin mode");
  AST_ERR_COUNT: assert property ((prbs_ev && error_count_source_top && s.err_cnt != 16'hffff)
      |=> s.err_cnt == $past(s.err_cnt) + 16'h0001)
    else $error("prbs error not counted");
endmodule : ldlp_top

// ---- ldlp_top_tb_top.sv ----
`timescale 1ns/1ps
module ldlp_top_tb_top;
  import ldlp_pkg::*;
  logic        clk = 0, srst = 1, hsel = 0, hwrite = 0, len = 0, lval = 0, tsc = 0, tsd = 0;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic        hready, rlc, rld, tlc, tld, rsc, rsd, perr;
  logic        hwm = 0;  // pin-mode strap
  logic [9:0]  cw;       // collected line bits of the code test
  int          errors = 0, cmp_count = 0;
  // system clock 200 MHz; system transmit clock free-running at 160 ns
  always #2.5 clk = ~clk;
  always #80 tsc = ~tsc;
  ldlp_top #(.QUAL_E1(40), .QUAL_T1(40), .INTEG_E1(16), .INTEG_T1(16)) uut (
    .CLK_SYS(clk), .SRST(srst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(), .RX_LINE_CLK(rlc), .RX_LINE_DATA(rld),
    .TX_LINE_CLK(tlc), .TX_LINE_DATA(tld), .TX_SYS_CLK(tsc), .TX_SYS_DATA(tsd),
    .RX_SYS_CLK(rsc), .RX_SYS_DATA(rsd), .PRBS_ERR_OUT(perr), .HW_MODE(hwm));
  ldlp_line_model far (.en(len), .val(lval), .lclk(rlc), .ldata(rld));
  //////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one single ahb transfer; the leading edge leaves an idle cycle between transfers
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int n = 0;
    @(posedge clk);
    hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= {22'h0, idx, 2'h0};
    do @(posedge clk); while (hready !== 1'b1 && ++n < 100);
    hsel <= 0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1 && ++n < 200);
    rd = hrdata;
  endtask : bus
  // set both data sources, then let three link bits pass
  task automatic bits(input logic s, input logic l);
    @(posedge clk);
    tsd <= s; lval <= l;
    repeat (3) @(negedge tsc);
  endtask : bits
  task automatic final_report;
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  //////////////////////////////////////////////////////////////////
  // watchdog: the whole run needs under 100 microseconds
  initial
  begin
    #200000;
    errors++;
    final_report();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 0;
    @(negedge clk);
    chk("error out", {31'h0, perr}, 32'h1);
    // pattern registers: reset zero, read back what was written, unmapped reads zero
    for (int i = 11; i <= 16; i++)
    begin
      bus(0, 8'(i), 0); chk("reset", rd, 32'h0);
      bus(1, 8'(i), {24'h0, 8'h5a ^ 8'(i)});
      bus(0, 8'(i), 0); chk("pattern", rd, {24'h0, 8'h5a ^ 8'(i)});
    end
    bus(0, 8'h20, 0); chk("unmapped", rd, 32'h0);
    $display("registers done");
    // local loop: system data reaches receive outputs, line ignored
    bus(1, IDX_CTRL6, 32'h1 << B_LLB);
    len <= 1;
    bits(1, 0); chk("local rx", {31'h0, rsd}, 32'h1);
    bits(0, 1); chk("local rx", {31'h0, rsd}, 32'h0);
    // all ones on the line while still looping system data
    bus(1, IDX_CTRL3, 32'h1 << B_ALL_ONES);
    bits(0, 0); chk("ones line", {31'h0, tld}, 32'h1);
    chk("ones rx", {31'h0, rsd}, 32'h0);
    bus(1, IDX_CTRL3, 0);
    $display("local loop done");
    // remote loop: line data goes back out, system data ignored
    bus(1, IDX_CTRL6, 32'h1 << B_RLB);
    bits(0, 1); chk("remote tx", {31'h0, tld}, 32'h1);
    chk("remote rx", {31'h0, rsd}, 32'h1);
    bits(1, 0); chk("remote tx", {31'h0, tld}, 32'h0);
    chk("remote rx", {31'h0, rsd}, 32'h0);
    // dual loop: both directions at once
    bus(1, IDX_CTRL6, (32'h1 << B_RLB) | (32'h1 << B_LLB));
    bits(1, 0); chk("dual tx", {31'h0, tld}, 32'h0);
    chk("dual rx", {31'h0, rsd}, 32'h1);
    // pin mode: the dual request falls back to local loop only
    @(posedge clk);
    hwm <= 1;
    bits(1, 0);
    chk("pin tx", {31'h0, tld}, 32'h1);
    chk("pin rx", {31'h0, rsd}, 32'h1);
    @(posedge clk);
    hwm <= 0;
    len <= 0;
    $display("remote loop done");
    // code generator: 5-bit pattern 10000, low bits of the byte are don't-cares
    bus(1, IDX_CTRL6, 0);
    bus(1, IDX_TX_LO, 32'h87);
    bus(1, IDX_CTRL3, 32'h1 << B_CODE_TX);
    repeat (2) @(negedge tsc);
    for (int i = 0; i < 10; i++)
    begin
      @(negedge tsc);
      cw = {cw[8:0], tld};
    end
    chk("code", {27'h0, cw[9:5] == cw[4:0], 4'($countones(cw))}, 32'h12);
    $display("code done");
    // prbs through analog loop: lock, then a standard switch breaks and regains sync
    bus(1, IDX_CTRL3, 32'h1 << B_PRBS_TX);
    bus(1, IDX_CTRL6, (32'h1 << B_ALB) | (32'h1 << B_ERROR_COUNT_SOURCE_TOP));
    repeat (120) @(negedge tsc);
    chk("prbs err", {31'h0, perr}, 32'h0);
    bus(0, IDX_STATUS, 0);
    chk("prbs sync", rd & 32'h1, 32'h1);
    bus(1, IDX_CTRL1, 32'h1 << B_STD);
    repeat (150) @(negedge tsc);
    bus(0, IDX_STATUS, 0);
    chk("t1 sync", rd & 32'h1, 32'h1);
    bus(0, IDX_ERR_LO, 0);
    chk("err count lo", rd, 32'h6);
    bus(0, IDX_ERR_HI, 0);
    chk("err count hi", rd, 32'h0);
    $display("prbs done");
    // automatic remote loop: loop-up code 0, loop-down code 1, one bit each
    bus(1, IDX_UP_LO, 0);
    bus(1, IDX_DN_LO, 32'h80);
    bus(1, IDX_CTRL6, 32'h1 << B_AUTO_REMOTE_LOOP_ENABLE);
    lval <= 0;
    len <= 1;
    repeat (100) @(negedge tsc);
    bus(0, IDX_STATUS, 0);
    chk("auto enter", rd & 32'hc2, 32'h82);
    bus(1, IDX_CTRL6, 0);
    bus(0, IDX_STATUS, 0);
    chk("auto clear", rd & 32'h2, 32'h0);
    bus(1, IDX_CTRL6, 32'h1 << B_AUTO_REMOTE_LOOP_ENABLE);
    repeat (60) @(negedge tsc);
    lval <= 1;
    repeat (100) @(negedge tsc);
    bus(0, IDX_STATUS, 0);
    chk("auto leave", rd & 32'hc2, 32'h40);
    len <= 0;
    $display("auto loop done");
    final_report();
  end
endmodule : ldlp_top_tb_top
